// >>> pkg/pcitw_pkg.sv
// Shared constants and types for the target wait-state read path
package pcitw_pkg;
  localparam int          PCITW_AW        = 32;
  localparam int          PCITW_BEW       = 4;
  localparam logic [3:0]  CMD_MEM_READ    = 4'h6;
  localparam logic [3:0]  CMD_READ_MULT   = 4'hc;
  localparam logic [3:0]  CMD_READ_LINE   = 4'he;
  localparam logic [3:0]  BE_ALL_N        = 4'h0;
  localparam logic [31:0] BAR_MASK        = 32'hffff_f000;
  localparam logic [31:0] BUS_PULLUP      = 32'hffff_ffff;
  localparam logic [31:0] WORD_STEP       = 32'h0000_0004;
  localparam logic [7:0]  WORDS_ONE       = 8'h01;
  localparam logic [2:0]  ABORT_CYCLES    = 3'h5;
  localparam logic [1:0]  HOLD_MAX        = 2'h2;

  typedef enum logic [2:0] {
    PT_IDLE    = 3'b000,
    PT_TURN    = 3'b001,
    PT_DECODE  = 3'b010,
    PT_DATA    = 3'b011,
    PT_RELEASE = 3'b100
  } pcitw_tgt_state_t;

  typedef enum logic [1:0] {
    PM_IDLE = 2'b00,
    PM_ADDR = 2'b01,
    PM_DATA = 2'b10,
    PM_TURN = 2'b11
  } pcitw_ini_state_t;
endpackage : pcitw_pkg

// >>> pkg/pcitw_if.sv
// Bus and local target port joining the target end and the master/back-end end
`timescale 1ns/100ps
interface pcitw_if;
  import pcitw_pkg::*;
  logic [31:0] ad_m;
  logic        ad_m_oe_n;
  logic [31:0] ad_t;
  logic        ad_t_oe_n;
  logic [31:0] ad;
  logic [3:0]  cben_m;
  logic        cben_oe_n;
  logic [3:0]  cben;
  logic        framen_m;
  logic        framen_oe_n;
  logic        framen;
  logic        irdyn_m;
  logic        irdyn_oe_n;
  logic        irdyn;
  logic        devseln_t;
  logic        devseln_oe_n;
  logic        devseln;
  logic        trdyn_t;
  logic        trdyn_oe_n;
  logic        trdyn;
  logic [31:0] local_addr_bus;
  logic        bar_hit;
  logic        backend_ready_n;
  logic        local_xfer_strobe_n;
  logic [31:0] local_data;

  // Released lines read high, as with pull-ups
  assign ad      = !ad_t_oe_n ? ad_t : (!ad_m_oe_n ? ad_m : BUS_PULLUP);
  assign cben    = !cben_oe_n ? cben_m : 4'hf;
  assign framen  = !framen_oe_n ? framen_m : 1'b1;
  assign irdyn   = !irdyn_oe_n ? irdyn_m : 1'b1;
  assign devseln = !devseln_oe_n ? devseln_t : 1'b1;
  assign trdyn   = !trdyn_oe_n ? trdyn_t : 1'b1;

  modport tgt (
    input  ad, cben, framen, irdyn, backend_ready_n, local_data,
    output ad_t, ad_t_oe_n, devseln_t, devseln_oe_n, trdyn_t, trdyn_oe_n,
    output local_addr_bus, bar_hit, local_xfer_strobe_n
  );
  modport ini (
    input  ad, devseln, trdyn, local_addr_bus, bar_hit, local_xfer_strobe_n,
    output ad_m, ad_m_oe_n, cben_m, cben_oe_n, framen_m, framen_oe_n, irdyn_m, irdyn_oe_n,
    output backend_ready_n, local_data
  );
endinterface : pcitw_if

// >>> verilog/pcitw_target.sv
// Target end: decode, devsel timing, wait states, local strobe and bus release
// Functional notes
// - Ready stays asserted until the phase completes
// - No target wait once trdyn committed
// - Hold data while master withholds irdyn
// - Back-end ready paces target wait states
// - Master drives framen, address, command first
// - Master floats ad, asserts irdyn next
// - Decode after turnaround; wait until trdyn
// - Slow devsel one clock after window match
// - Strobe only after irdyn and ready
// - Master wait drops the local strobe
// - trdyn and word follow first strobe
// - Steady ready keeps trdyn across words
// - Back-end steps address per strobe
// - Master waits via irdyn, then byte enables
// - Last phase: framen high, irdyn low
// - After last phase drive devseln, trdyn high
// - Then float devseln and trdyn
// - Window match output acts as select
// - Captured address shown during turnaround
`timescale 1ns/100ps
module pcitw_target
  import pcitw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic [31:0] bar_base,
  input  wire logic        devsel_slow,
  output logic             selected,
  pcitw_if.tgt             bus
);

  pcitw_tgt_state_t state;
  pcitw_tgt_state_t next_state;
  logic [31:0] addr_q;
  logic [31:0] next_addr_q;
  logic [3:0]  cmd_q;
  logic [3:0]  next_cmd_q;
  logic        hit_q;
  logic        next_hit_q;
  logic        devsel_q;
  logic        next_devsel_q;
  logic        drive_q;
  logic        next_drive_q;
  logic        trdy_q;
  logic        next_trdy_q;
  logic [31:0] word_q;
  logic [31:0] next_word_q;
  logic        pend_q;
  logic        next_pend_q;
  logic [31:0] pend_word_q;
  logic [31:0] next_pend_word_q;
  logic        strobe_q;
  logic        next_strobe_q;
  logic        match;
  logic        read_cmd;
  logic        complete;
  logic [1:0]  held_after;
  logic        framen_q;
  logic        next_framen_q;
  logic        fetch_ok;

  assign read_cmd = (cmd_q == CMD_MEM_READ) || (cmd_q == CMD_READ_MULT) || (cmd_q == CMD_READ_LINE);
  assign match    = ((addr_q & BAR_MASK) == (bar_base & BAR_MASK)) && read_cmd;
  // Phase completes only when both parties are ready together
  assign complete = trdy_q && !bus.irdyn;

  always_comb begin
    next_state       = state;
    next_addr_q      = addr_q;
    next_cmd_q       = cmd_q;
    next_hit_q       = hit_q;
    next_devsel_q    = devsel_q;
    next_drive_q     = drive_q;
    next_trdy_q      = trdy_q;
    next_word_q      = word_q;
    next_pend_q      = pend_q;
    next_pend_word_q = pend_word_q;
    next_strobe_q    = 1'b0;
    held_after       = 2'(trdy_q) + 2'(pend_q) + 2'(strobe_q) - 2'(complete);
    next_framen_q    = bus.framen;
    fetch_ok         = 1'b0;
    case (state)
      PT_IDLE: begin
        next_drive_q  = 1'b0;
        next_devsel_q = 1'b0;
        next_trdy_q   = 1'b0;
        next_pend_q   = 1'b0;
        next_hit_q    = 1'b0;
        // Only a falling framen opens an address phase, not an aborted one still low
        if (!bus.framen && framen_q) begin
          next_addr_q = bus.ad;
          next_cmd_q  = bus.cben;
          next_state  = PT_TURN;
        end
      end
      PT_TURN: begin
        // Address is on the local bus this cycle; decode result lands next
        next_hit_q = match;
        if (match && !devsel_slow) begin
          next_devsel_q = 1'b1;
          next_drive_q  = 1'b1;
        end
        next_state = PT_DECODE;
      end
      PT_DECODE: begin
        if (!hit_q) begin
          next_state = PT_IDLE;
        end else begin
          next_devsel_q = 1'b1;
          next_drive_q  = 1'b1;
          next_state    = PT_DATA;
        end
      end
      PT_DATA: begin
        // Word arriving with the strobe goes to the bus slot or the spare slot
        if (complete) begin
          if (pend_q) begin
            next_word_q = pend_word_q;
            next_pend_q = 1'b0;
            if (strobe_q) begin
              next_pend_word_q = bus.local_data;
              next_pend_q      = 1'b1;
            end
          end else if (strobe_q) begin
            next_word_q = bus.local_data;
          end else begin
            next_trdy_q = 1'b0;
          end
        end else if (strobe_q) begin
          if (trdy_q) begin
            next_pend_word_q = bus.local_data;
            next_pend_q      = 1'b1;
          end else begin
            next_word_q = bus.local_data;
            next_trdy_q = 1'b1;
          end
        end
        // Fetch only when the master and back-end were both ready and room remains
        // Last phase fetches only when no word is held for the bus
        fetch_ok = !bus.framen || (held_after == 2'h0 && !complete);
        if (!bus.irdyn && !bus.backend_ready_n && fetch_ok && held_after < HOLD_MAX) begin
          next_strobe_q = 1'b1;
        end
        if (complete && bus.framen) begin
          next_state    = PT_RELEASE;
          next_devsel_q = 1'b0;
          next_trdy_q   = 1'b0;
          next_pend_q   = 1'b0;
          next_hit_q    = 1'b0;
        end
      end
      PT_RELEASE: begin
        next_drive_q = 1'b0;
        next_state   = PT_IDLE;
      end
      default: begin
        next_state = PT_IDLE;
      end
    endcase
  end

  // State advances only while ce is high
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state       <= PT_IDLE;
      framen_q    <= 1'b1;
      addr_q      <= '0;
      cmd_q       <= '0;
      hit_q       <= 1'b0;
      devsel_q    <= 1'b0;
      drive_q     <= 1'b0;
      trdy_q      <= 1'b0;
      word_q      <= '0;
      pend_q      <= 1'b0;
      pend_word_q <= '0;
      strobe_q    <= 1'b0;
    end else if (ce) begin
      state       <= next_state;
      addr_q      <= next_addr_q;
      cmd_q       <= next_cmd_q;
      hit_q       <= next_hit_q;
      devsel_q    <= next_devsel_q;
      drive_q     <= next_drive_q;
      trdy_q      <= next_trdy_q;
      word_q      <= next_word_q;
      pend_q      <= next_pend_q;
      pend_word_q <= next_pend_word_q;
      strobe_q    <= next_strobe_q;
      framen_q    <= next_framen_q;
    end
  end

  assign bus.local_addr_bus      = addr_q;
  assign bus.bar_hit             = hit_q;
  assign bus.local_xfer_strobe_n = !strobe_q;
  assign bus.devseln_t           = !devsel_q;
  assign bus.trdyn_t             = !trdy_q;
  assign bus.devseln_oe_n        = !drive_q;
  assign bus.trdyn_oe_n          = !drive_q;
  assign bus.ad_t                = word_q;
  assign bus.ad_t_oe_n           = !(state == PT_DATA);
  assign selected                = hit_q;

endmodule : pcitw_target

// >>> verilog/pcitw_initiator.sv
// Far end: bus master issuing reads plus the back-end supplying words
`timescale 1ns/100ps
module pcitw_initiator
  import pcitw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        req,
  input  wire logic [31:0] req_addr,
  input  wire logic [7:0]  req_words,
  input  wire logic        master_wait,
  input  wire logic        backend_stall,
  output logic             busy,
  output logic [31:0]      rdata,
  output logic             rdata_valid,
  output logic             done,
  output logic             aborted,
  output logic [31:0]      backend_addr,
  pcitw_if.ini             bus
);

  pcitw_ini_state_t state;
  pcitw_ini_state_t next_state;
  logic [31:0] addr_q;
  logic [31:0] next_addr_q;
  logic [7:0]  left_q;
  logic [7:0]  next_left_q;
  logic        irdy_q;
  logic        next_irdy_q;
  logic [2:0]  wait_q;
  logic [2:0]  next_wait_q;
  logic [31:0] next_rdata;
  logic        next_rdata_valid;
  logic        next_done;
  logic        next_aborted;
  logic        last;
  logic        complete;
  logic [31:0] cnt_q;
  logic [31:0] next_cnt_q;
  logic        hit_seen;
  logic        next_hit_seen;

  assign last     = (left_q == WORDS_ONE);
  assign complete = irdy_q && !bus.trdyn;

  always_comb begin
    next_state       = state;
    next_addr_q      = addr_q;
    next_left_q      = left_q;
    next_irdy_q      = irdy_q;
    next_wait_q      = wait_q;
    next_rdata       = rdata;
    next_rdata_valid = 1'b0;
    next_done        = 1'b0;
    next_aborted     = aborted;
    case (state)
      PM_IDLE: begin
        next_irdy_q = 1'b0;
        if (req) begin
          next_addr_q  = req_addr;
          next_left_q  = (req_words == 8'h00) ? WORDS_ONE : req_words;
          next_wait_q  = '0;
          next_aborted = 1'b0;
          next_state   = PM_ADDR;
        end
      end
      PM_ADDR: begin
        next_irdy_q = !master_wait;
        next_state  = PM_DATA;
      end
      PM_DATA: begin
        // Once asserted, irdyn holds until the target is ready too or the read aborts
        next_irdy_q = (irdy_q && !complete) ? 1'b1 : !master_wait;
        if (bus.devseln && wait_q != ABORT_CYCLES) begin
          next_wait_q = wait_q + 3'h1;
        end
        if (complete) begin
          next_rdata       = bus.ad;
          next_rdata_valid = 1'b1;
          next_left_q      = left_q - WORDS_ONE;
          if (last) begin
            next_irdy_q = 1'b0;
            next_state  = PM_TURN;
          end
        end else if (bus.devseln && wait_q == ABORT_CYCLES) begin
          next_irdy_q  = 1'b0;
          next_aborted = 1'b1;
          next_state   = PM_TURN;
        end
      end
      PM_TURN: begin
        next_done  = 1'b1;
        next_state = PM_IDLE;
      end
      default: begin
        next_state = PM_IDLE;
      end
    endcase
  end

  // Back-end word counter steps once per local strobe
  always_comb begin
    next_hit_seen = bus.bar_hit;
    next_cnt_q    = cnt_q;
    if (bus.bar_hit && !hit_seen) begin
      next_cnt_q = bus.local_addr_bus;
    end else if (bus.bar_hit && !bus.local_xfer_strobe_n) begin
      next_cnt_q = cnt_q + WORD_STEP;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state       <= PM_IDLE;
      addr_q      <= '0;
      left_q      <= '0;
      irdy_q      <= 1'b0;
      wait_q      <= '0;
      rdata       <= '0;
      rdata_valid <= 1'b0;
      done        <= 1'b0;
      aborted     <= 1'b0;
      cnt_q       <= '0;
      hit_seen    <= 1'b0;
    end else if (ce) begin
      state       <= next_state;
      addr_q      <= next_addr_q;
      left_q      <= next_left_q;
      irdy_q      <= next_irdy_q;
      wait_q      <= next_wait_q;
      rdata       <= next_rdata;
      rdata_valid <= next_rdata_valid;
      done        <= next_done;
      aborted     <= next_aborted;
      cnt_q       <= next_cnt_q;
      hit_seen    <= next_hit_seen;
    end
  end

  assign busy                = (state != PM_IDLE);
  assign bus.ad_m            = addr_q;
  assign bus.ad_m_oe_n       = !(state == PM_ADDR);
  assign bus.cben_m          = (state == PM_ADDR) ? CMD_MEM_READ : BE_ALL_N;
  assign bus.cben_oe_n       = !(state == PM_ADDR || state == PM_DATA);
  assign bus.framen_m        = !(state == PM_ADDR || (state == PM_DATA && !(last && irdy_q)));
  assign bus.framen_oe_n     = !(state == PM_ADDR || state == PM_DATA);
  assign bus.irdyn_m         = !irdy_q;
  assign bus.irdyn_oe_n      = !(state == PM_DATA || state == PM_TURN);
  assign bus.backend_ready_n = !(bus.bar_hit && !backend_stall);
  assign bus.local_data      = cnt_q;
  assign backend_addr        = cnt_q;

endmodule : pcitw_initiator

// >>> verif/pcitw_bus_assertions.sv
// Concurrent checks on the bus and local target port
`timescale 1ns/100ps
module pcitw_bus_assertions (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        devsel_slow,
  input wire logic [31:0] ad,
  input wire logic        framen,
  input wire logic        irdyn,
  input wire logic        devseln,
  input wire logic        trdyn,
  input wire logic        devseln_t,
  input wire logic        devseln_oe_n,
  input wire logic        trdyn_t,
  input wire logic        trdyn_oe_n,
  input wire logic [31:0] local_addr_bus,
  input wire logic        bar_hit,
  input wire logic        backend_ready_n,
  input wire logic        local_xfer_strobe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_trdy_hold;
    !trdyn && irdyn |=> !trdyn && $stable(ad);
  endproperty
  a_trdy_hold: assert property (p_trdy_hold) else $error("target dropped data in master wait");

  property p_irdy_hold;
    !irdyn && trdyn && !devseln |=> !irdyn;
  endproperty
  a_irdy_hold: assert property (p_irdy_hold) else $error("master withdrew irdyn");

  property p_strobe_cause;
    !local_xfer_strobe_n |-> !$past(irdyn) && !$past(backend_ready_n);
  endproperty
  a_strobe_cause: assert property (p_strobe_cause) else $error("strobe without cause");

  property p_strobe_drop;
    irdyn |=> local_xfer_strobe_n;
  endproperty
  a_strobe_drop: assert property (p_strobe_drop) else $error("strobe after master wait");

  property p_first_data;
    !local_xfer_strobe_n && trdyn && !devseln |=> !trdyn;
  endproperty
  a_first_data: assert property (p_first_data) else $error("trdyn late after strobe");

  property p_release;
    !trdyn && !irdyn && framen |=> (!devseln_oe_n && !trdyn_oe_n && devseln_t && trdyn_t) ##1 (devseln_oe_n && trdyn_oe_n);
  endproperty
  a_release: assert property (p_release) else $error("bad release after last phase");

  property p_addr_capture;
    $fell(framen) |=> local_addr_bus == $past(ad);
  endproperty
  a_addr_capture: assert property (p_addr_capture) else $error("local address not captured");

  property p_devsel_time;
    $rose(bar_hit) |-> if (devsel_slow) (devseln ##1 !devseln) else !devseln;
  endproperty
  a_devsel_time: assert property (p_devsel_time) else $error("devseln timing wrong");
endmodule : pcitw_bus_assertions

// >>> verif/pci_target_wait_states_tb.sv
// Bench joining the target and initiator ends
`timescale 1ns/100ps
module pci_target_wait_states_tb;
  import pcitw_pkg::*;
  logic        clk;
  logic        rstn;
  logic        ce;
  logic [31:0] bar_base;
  logic        devsel_slow;
  logic        selected;
  logic        req;
  logic [31:0] req_addr;
  logic [7:0]  req_words;
  logic        master_wait;
  logic        backend_stall;
  logic        rand_on;
  logic        busy;
  logic [31:0] rdata;
  logic        rdata_valid;
  logic        done;
  logic        aborted;
  logic [31:0] backend_addr;
  logic        seen_sel;
  int          fail_count;
  int          checks;
  int          seed;
  logic [31:0] qr[$];
  logic [31:0] qb[$];

  pcitw_if bus_if ();
  pcitw_target pcitw_target_i (.clk(clk), .rstn(rstn), .ce(ce), .bar_base(bar_base),
    .devsel_slow(devsel_slow), .selected(selected), .bus(bus_if.tgt));
  pcitw_initiator pcitw_initiator_i (.clk(clk), .rstn(rstn), .ce(ce), .req(req), .req_addr(req_addr),
    .req_words(req_words), .master_wait(master_wait), .backend_stall(backend_stall), .busy(busy),
    .rdata(rdata), .rdata_valid(rdata_valid), .done(done), .aborted(aborted),
    .backend_addr(backend_addr), .bus(bus_if.ini));
  pcitw_bus_assertions pcitw_bus_assertions_i (.clk(clk), .rstn(rstn), .devsel_slow(devsel_slow),
    .ad(bus_if.ad), .framen(bus_if.framen), .irdyn(bus_if.irdyn), .devseln(bus_if.devseln),
    .trdyn(bus_if.trdyn), .devseln_t(bus_if.devseln_t), .devseln_oe_n(bus_if.devseln_oe_n),
    .trdyn_t(bus_if.trdyn_t), .trdyn_oe_n(bus_if.trdyn_oe_n), .local_addr_bus(bus_if.local_addr_bus),
    .bar_hit(bus_if.bar_hit), .backend_ready_n(bus_if.backend_ready_n),
    .local_xfer_strobe_n(bus_if.local_xfer_strobe_n));

  always #10 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  // One read; expected words noted for both monitors
  task automatic run_read(input logic [31:0] addr, input logic [7:0] words, input logic miss);
    int n;
    int k;
    n = (words == 8'h00) ? 1 : int'(words);
    for (k = 0; k < n && !miss; k++) begin
      qr.push_back(addr + WORD_STEP * 32'(k));
      qb.push_back(addr + WORD_STEP * 32'(k));
    end
    @(negedge clk);
    req = 1'b1;
    req_addr = addr;
    req_words = words;
    seen_sel = 1'b0;
    @(negedge clk);
    req = 1'b0;
    k = 0;
    while (busy !== 1'b0 && k < 400) begin
      seen_sel = seen_sel | selected;
      @(negedge clk);
      k++;
    end
    check({31'h0, done}, 32'h0000_0001);
    if (!miss) begin
      check({31'h0, (backend_addr >= addr + WORD_STEP * 32'(n)) &&
             (backend_addr <= addr + WORD_STEP * 32'(n + 1))}, 32'h0000_0001);
    end
    check({31'h0, aborted}, {31'h0, miss});
    check({31'h0, seen_sel}, {31'h0, !miss});
    check(32'(qr.size() + qb.size()), 32'h0000_0000);
    repeat (2) @(negedge clk);
    check({26'h0, bus_if.framen, bus_if.irdyn, bus_if.devseln, bus_if.trdyn,
           bus_if.devseln_oe_n, bus_if.trdyn_oe_n}, 32'h0000_003f);
    check(bus_if.ad, BUS_PULLUP);
  endtask : run_read

  // Local side results in order
  always @(negedge clk) begin
    if (rstn === 1'b1 && rdata_valid === 1'b1) begin
      if (qr.size() == 0) begin
        check(32'h0000_0000, 32'h0000_0001);
      end else begin
        check(rdata, qr.pop_front());
      end
    end
  end

  // Bus completions carry the ascending words
  always @(negedge clk) begin
    if (rstn === 1'b1 && bus_if.trdyn === 1'b0 && bus_if.irdyn === 1'b0) begin
      check(bus_if.ad, (qb.size() == 0) ? ~bus_if.ad : qb.pop_front());
      check({28'h0, bus_if.cben}, {28'h0, BE_ALL_N});
    end
  end

  // Random master and back-end stalls
  always @(negedge clk) begin
    if (rand_on) begin
      master_wait = ($urandom_range(3, 0) == 0);
      backend_stall = ($urandom_range(3, 0) == 0);
    end
  end

  initial begin
    #400000;
    fail_count++;
    give_verdict();
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    ce = 1'b1;
    bar_base = 32'h4000_0000;
    devsel_slow = 1'b1;
    req = 1'b0;
    req_addr = 32'h0000_0000;
    req_words = 8'h00;
    master_wait = 1'b0;
    backend_stall = 1'b0;
    rand_on = 1'b0;
    seen_sel = 1'b0;
    fail_count = 0;
    checks = 0;
    seed = $urandom(29);
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    run_read(32'h4000_0000, 8'h02, 1'b0);
    devsel_slow = 1'b0;
    run_read(32'h4000_0100, 8'h00, 1'b0);
    master_wait = 1'b1;
    fork
      run_read(32'h4000_0200, 8'h03, 1'b0);
      begin
        repeat (9) @(negedge clk);
        master_wait = 1'b0;
      end
    join
    devsel_slow = 1'b1;
    backend_stall = 1'b1;
    fork
      run_read(32'h4000_0300, 8'h04, 1'b0);
      begin
        repeat (9) @(negedge clk);
        backend_stall = 1'b0;
      end
    join
    run_read(32'h4000_0ffc, 8'h01, 1'b0);
    run_read(32'h4000_1000, 8'h02, 1'b1);
    ce = 1'b0;
    req = 1'b1;
    repeat (3) @(negedge clk);
    check({31'h0, busy}, 32'h0000_0000);
    req = 1'b0;
    ce = 1'b1;
    rand_on = 1'b1;
    for (int i = 0; i < 16; i++) begin
      devsel_slow = 1'($urandom_range(1, 0));
      run_read(32'h4000_0000 + 32'($urandom_range(1016, 0) * 4), 8'($urandom_range(8, 1)), 1'b0);
    end
    rand_on = 1'b0;
    give_verdict();
  end
endmodule : pci_target_wait_states_tb
